// ### src/calib_pkg.sv
// constants shared by the memory-device end and the controller end
// assumes both ends see the same command encoding and mode register layout
package calib_pkg;
  // =========================================
  // command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_SRE = 4'h1;
  // =========================================
  // mode register selects on bank address
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_TWO = 3'h2;
  localparam logic [2:0] MR_THREE = 3'h3;
  // field positions
  localparam int BIT_LOOP_OFF = 0;
  localparam int BIT_CALIB_EN = 2;
  localparam int BIT_CHOP_SEL = 12;
  localparam int BIT_NIBBLE = 2;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  // mode_reg_zero burst field: 2'h1 = on-the-fly chop, 2'h2 = fixed chop
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
  // =========================================
  // latencies and reset values
  localparam logic [2:0] LOOP_OFF_LATENCY = 3'h6;
  localparam logic [2:0] RESET_LATENCY = 3'h6;
  localparam logic [7:0] CALIB_PATTERN = 8'hAA;
  // =========================================
  // controller timing, in link cycles
  localparam int MOD_DELAY_CYC = 12;
  localparam int SR_ENTRY_HOLD_CYC = 5;
  localparam int SR_EXIT_STABLE_CYC = 5;
  localparam int SR_EXIT_DELAY_CYC = 24;
  localparam int CLK_DIV = 2;
endpackage

// ### src/dram_link_if.sv
// command and data pins between controller and memory device
// assumes the controller drives link_clk; data lanes are split drive/enable
`timescale 1ns/100ps
interface dram_link_if;
  logic link_clk;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq_out;
  logic dq_upper_out;
  logic dq_oe;
  logic strobe;
  modport device (input link_clk, input cke, input cs_n, input ras_n, input cas_n, input we_n, input odt,
    input ba, input addr, output dq_out, output dq_upper_out, output dq_oe, output strobe);
  modport host (output link_clk, output cke, output cs_n, output ras_n, output cas_n, output we_n, output odt,
    output ba, output addr, input dq_out, input dq_upper_out, input dq_oe, input strobe);
endinterface

// ### src/calib_device.sv
// memory device end: mode registers, calibration readout, loop-off read timing
// assumes link_clk comes from the controller; all device logic runs on it
`timescale 1ns/100ps
module calib_device #(
  parameter int DQ_COPY = 1
) (
  input wire logic rst_n,
  dram_link_if.device link,
  output logic loop_off,
  output logic calib_mode
);
  logic [15:0] mr0, next_mr0, mr1, next_mr1, mr3, next_mr3;
  logic [15:0] lat_pipe, next_lat_pipe;
  logic chop, next_chop, nib, next_nib, loc_zero, next_loc_zero;
  logic [3:0] beat, next_beat;
  logic active, next_active;
  logic [7:0] dq, next_dq;
  logic upper_data_lane, next_dqu, oe, next_oe;
  logic [3:0] cmd;
  logic [4:0] delay;
  logic start;
  // =========================================
  // command decode
  always_comb begin
    cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    // selected read with cs high never matches since cmd[3] is checked
    start = link.cke && !link.cs_n && cmd[2:0] == calib_pkg::CMD_READ[2:0];
    // start latency position: loop off shifts the strobe one cycle earlier
    delay = {2'h0, mr0[calib_pkg::LAT_MSB:calib_pkg::LAT_LSB]} - {4'h0, mr1[calib_pkg::BIT_LOOP_OFF]};
  end
  always_comb begin
    next_mr0 = mr0;
    next_mr1 = mr1;
    next_mr3 = mr3;
    // marker walks down to bit zero, one position per link cycle
    next_lat_pipe = {1'b0, lat_pipe[15:1]};
    next_chop = chop;
    next_nib = nib;
    next_loc_zero = loc_zero;
    if (link.cke && cmd == calib_pkg::CMD_MRS) begin
      if (link.ba == calib_pkg::MR_ZERO) next_mr0 = {2'h0, link.addr};
      if (link.ba == calib_pkg::MR_ONE) next_mr1 = {2'h0, link.addr};
      if (link.ba == calib_pkg::MR_THREE) next_mr3 = {2'h0, link.addr};
    end
    // no-operation and deselect fall through: pipeline keeps running
    if (start && mr3[calib_pkg::BIT_CALIB_EN]) begin
      // ignores bank, A10 and all upper column bits except chop select
      next_lat_pipe[delay[3:0]] = 1'b1;
      next_chop = (mr0[1:0] == calib_pkg::BURST_FIXED_CHOP) ||
        (mr0[1:0] == calib_pkg::BURST_OTF && !link.addr[calib_pkg::BIT_CHOP_SEL]);
      next_nib = link.addr[calib_pkg::BIT_NIBBLE];
      next_loc_zero = mr3[1:0] == 2'h0;
    end
  end
  always_comb begin
    next_beat = beat;
    next_active = active;
    next_oe = 1'b0;
    next_dq = 8'h00;
    next_dqu = 1'b0;
    if (lat_pipe[0]) begin
      next_active = 1'b1;
      next_beat = chop && nib ? 4'h4 : 4'h0;
    end else if (active) begin
      next_beat = beat + 4'h1;
      if (next_beat == (chop ? (nib ? 4'h8 : 4'h4) : 4'h8)) next_active = 1'b0;
    end
    if (next_active) begin
      next_oe = 1'b1;
      // undefined locations read as zero
      next_dqu = loc_zero & calib_pkg::CALIB_PATTERN[next_beat[2:0]];
      next_dq = DQ_COPY != 0 ? {8{next_dqu}} : {7'h00, next_dqu};
    end
  end
  always_ff @(posedge link.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr0 <= {9'h000, calib_pkg::RESET_LATENCY, 4'h0};
      mr1 <= 16'h0000;
      mr3 <= 16'h0000;
      lat_pipe <= 16'h0000;
      chop <= 1'b0;
      nib <= 1'b0;
      loc_zero <= 1'b0;
      beat <= 4'h0;
      active <= 1'b0;
      dq <= 8'h00;
      upper_data_lane <= 1'b0;
      oe <= 1'b0;
    end else begin
      mr0 <= next_mr0;
      mr1 <= next_mr1;
      mr3 <= next_mr3;
      lat_pipe <= next_lat_pipe;
      chop <= next_chop;
      nib <= next_nib;
      loc_zero <= next_loc_zero;
      beat <= next_beat;
      active <= next_active;
      dq <= next_dq;
      upper_data_lane <= next_dqu;
      oe <= next_oe;
    end
  end
  assign link.dq_out = dq;
  assign link.dq_upper_out = upper_data_lane;
  assign link.dq_oe = oe;
  assign link.strobe = oe;
  assign loop_off = mr1[calib_pkg::BIT_LOOP_OFF];
  assign calib_mode = mr3[calib_pkg::BIT_CALIB_EN];
endmodule

// ### src/calib_host.sv
// controller end: loop-off switch procedure and calibration reads
// assumes user requests are levels/pulses on clk; link clock is divided from clk
`timescale 1ns/100ps
// Behaviour
// - bit on lane zero and upper bit zero
// - column bits 1:0 zero; ignore bank/high bits
// - burst of eight returns beats zero to seven
// - chop uses column bit two nibble
// - column bit twelve chops when enabled
// - beat zero is register lsb
// - location zero returns alternating pattern
// - calibration reads keep normal read latency
// - reads only after loop locked
// - no-operation starts nothing new
// - deselect ignores all command pins
// - mode one bit zero disables loop
// - loop off supports latency six only
// - loop off strobe one cycle earlier
// - idle, write loop off, wait update delay
// - hold clock, change, stabilise, then exit; the link clock divide from clk is never changed
// - clock enable high through update delays
// - termination low if it was enabled
// - rewrite modes after exit delay; the code rewrites mode zero only
// - mode three bit two enables readout
// - readout treats autoprecharge read as read
module calib_host #(
  parameter logic ODT_WAS_ON = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go_loop_off,
  input wire logic calib_read,
  input wire logic calib_chop,
  input wire logic calib_upper,
  input wire logic loop_locked,
  output logic busy,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  dram_link_if.host link
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_MR1 = 4'h1, S_MOD = 4'h2, S_SRE = 4'h3, S_HOLD = 4'h4, S_STABLE = 4'h5,
    S_EXIT = 4'h6, S_XS = 4'h7, S_MR0 = 4'h8, S_MOD2 = 4'h9, S_CAL = 4'hA, S_RD = 4'hB, S_WAIT = 4'hC,
    S_CAL3 = 4'hD
  } state_t;
  state_t state, next_state;
  logic div, next_div;
  logic [5:0] cnt, next_cnt;
  logic [3:0] cmd, next_cmd;
  logic [13:0] addr, next_addr;
  logic [2:0] ba, next_ba;
  logic cke, next_cke;
  logic [7:0] shreg, next_shreg;
  logic [3:0] got, next_got;
  logic [7:0] out_byte, next_out_byte;
  logic out_v, next_out_v;
  logic [1:0] oe_sync, next_oe_sync;
  logic [1:0] up_sync, next_up_sync;
  logic loop_off_sent, next_loop_off_sent;
  wire edge_now = div == 1'b1;
  // =========================================
  // procedure, advanced once per link clock falling edge
  always_comb begin
    next_div = ~div;
    next_state = state;
    next_cnt = cnt;
    next_cmd = cmd;
    next_addr = addr;
    next_ba = ba;
    next_cke = cke;
    next_loop_off_sent = loop_off_sent;
    if (edge_now) begin
      next_cmd = calib_pkg::CMD_NOP;
      if (cnt != 6'h00) next_cnt = cnt - 6'h01;
      case (state)
        S_IDLE: begin
          if (go_loop_off) next_state = S_MR1;
          else if (calib_read && loop_locked) next_state = S_CAL;
        end
        S_MR1: begin
          next_cmd = calib_pkg::CMD_MRS;
          next_loop_off_sent = 1'b1;
          next_ba = calib_pkg::MR_ONE;
          next_addr = 14'h0001;
          next_cnt = 6'(calib_pkg::MOD_DELAY_CYC);
          next_state = S_MOD;
        end
        S_MOD: if (cnt == 6'h00) next_state = S_SRE;
        S_SRE: begin
          next_cmd = calib_pkg::CMD_SRE;
          next_cke = 1'b0;
          next_cnt = 6'(calib_pkg::SR_ENTRY_HOLD_CYC);
          next_state = S_HOLD;
        end
        S_HOLD: if (cnt == 6'h00) begin
          next_cnt = 6'(calib_pkg::SR_EXIT_STABLE_CYC);
          next_state = S_STABLE;
        end
        S_STABLE: if (cnt == 6'h00) next_state = S_EXIT;
        S_EXIT: begin
          next_cke = 1'b1;
          next_cnt = 6'(calib_pkg::SR_EXIT_DELAY_CYC);
          next_state = S_XS;
        end
        S_XS: if (cnt == 6'h00) next_state = S_MR0;
        S_MR0: begin
          next_cmd = calib_pkg::CMD_MRS;
          next_ba = calib_pkg::MR_ZERO;
          next_addr = {7'h00, calib_pkg::LOOP_OFF_LATENCY, 2'h0, calib_pkg::BURST_OTF};
          next_cnt = 6'(calib_pkg::MOD_DELAY_CYC);
          next_state = S_MOD2;
        end
        S_MOD2: if (cnt == 6'h00) next_state = S_IDLE;
        // on-the-fly burst field first, so column bit twelve can chop each read
        S_CAL: begin
          next_cmd = calib_pkg::CMD_MRS;
          next_ba = calib_pkg::MR_ZERO;
          next_addr = {7'h00, loop_off_sent ? calib_pkg::LOOP_OFF_LATENCY : calib_pkg::RESET_LATENCY, 2'h0,
            calib_pkg::BURST_OTF};
          next_cnt = 6'(calib_pkg::MOD_DELAY_CYC);
          next_state = S_CAL3;
        end
        S_CAL3: if (cnt == 6'h00) begin
          next_cmd = calib_pkg::CMD_MRS;
          next_ba = calib_pkg::MR_THREE;
          next_addr = 14'h0004;
          next_cnt = 6'(calib_pkg::MOD_DELAY_CYC);
          next_state = S_RD;
        end
        S_RD: if (cnt == 6'h00) begin
          next_cmd = calib_pkg::CMD_READ;
          next_ba = 3'h0;
          // column bits 1:0 zero; bit two picks the nibble only when chopping
          next_addr = {1'b0, ~calib_chop, 9'h000, calib_chop & calib_upper, 2'h0};
          next_cnt = 6'h20;
          next_state = S_WAIT;
        end
        // readout is switched off again, since only reads may follow while it is on
        S_WAIT: if (cnt == 6'h00) begin
          next_cmd = calib_pkg::CMD_MRS;
          next_ba = calib_pkg::MR_THREE;
          next_addr = 14'h0000;
          next_cnt = 6'(calib_pkg::MOD_DELAY_CYC);
          next_state = S_MOD2;
        end
        default: next_state = S_IDLE;
      endcase
    end
  end
  // =========================================
  // data capture on the rising clk edge that ends the link clock high half
  always_comb begin
    next_shreg = shreg;
    next_got = got;
    next_out_v = 1'b0;
    next_out_byte = out_byte;
    // two flops on both lanes: data comes from the link clock domain, both delayed alike
    next_oe_sync = {oe_sync[0], link.dq_oe};
    next_up_sync = {up_sync[0], link.dq_upper_out};
    if (edge_now) begin
      if (oe_sync[1]) begin
        next_shreg = {up_sync[1], shreg[7:1]};
        next_got = got + 4'h1;
      end else if (got != 4'h0) begin
        next_out_byte = shreg >> (4'h8 - got);
        next_out_v = 1'b1;
        next_got = 4'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 1'b0;
      state <= S_IDLE;
      cnt <= 6'h00;
      cmd <= calib_pkg::CMD_NOP;
      addr <= 14'h0000;
      ba <= 3'h0;
      cke <= 1'b1;
      shreg <= 8'h00;
      got <= 4'h0;
      out_byte <= 8'h00;
      out_v <= 1'b0;
      oe_sync <= 2'h0;
      up_sync <= 2'h0;
      loop_off_sent <= 1'b0;
    end else begin
      div <= next_div;
      state <= next_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      addr <= next_addr;
      ba <= next_ba;
      cke <= next_cke;
      shreg <= next_shreg;
      got <= next_got;
      out_byte <= next_out_byte;
      out_v <= next_out_v;
      oe_sync <= next_oe_sync;
      up_sync <= next_up_sync;
      loop_off_sent <= next_loop_off_sent;
    end
  end
  // link clock rises when div goes high; commands change when it falls and are taken next rise
  assign link.link_clk = div;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd;
  assign link.addr = addr;
  assign link.ba = ba;
  assign link.cke = cke;
  assign link.odt = ODT_WAS_ON ? 1'b0 : 1'b0;
  assign busy = state != S_IDLE;
  assign rd_byte = out_byte;
  assign rd_valid = out_v;
endmodule

// ### tb/dram_link_assertions.sv
// checker for the command and data pins between controller and memory device
// assumes it sits beside the link interface and watches it on the link clock
`timescale 1ns/100ps
module dram_link_assertions (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic dq_upper_out,
  input wire logic dq_oe,
  input wire logic strobe
);
  // =========================================
  // helper state: cycles since last mode write, loop-off copy, readout-enable copy
  logic rd, mrs, cmd, lo, next_lo;
  logic cal, next_cal;
  int gap, next_gap;
  assign rd = cke && {cs_n, ras_n, cas_n, we_n} == calib_pkg::CMD_READ;
  assign mrs = cke && {cs_n, ras_n, cas_n, we_n} == calib_pkg::CMD_MRS;
  assign cmd = !cs_n && {ras_n, cas_n, we_n} != 3'h7;
  always_comb begin
    next_gap = mrs ? 1 : (gap < 99 ? gap + 1 : gap);
    next_lo = (mrs && ba == calib_pkg::MR_ONE) ? addr[calib_pkg::BIT_LOOP_OFF] : lo;
    next_cal = (mrs && ba == calib_pkg::MR_THREE) ? addr[calib_pkg::BIT_CALIB_EN] : cal;
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 99;
      lo <= 1'b0;
      cal <= 1'b0;
    end else begin
      gap <= next_gap;
      lo <= next_lo;
      cal <= next_cal;
    end
  end
  // =========================================
  // properties
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  a_cmd_after_mode: assert property (cmd |-> gap >= calib_pkg::MOD_DELAY_CYC)
    else $error("command too soon after mode write");
  a_sr_hold_low: assert property ($fell(cke) |-> !cke [*8])
    else $error("self refresh left too early");
  a_sr_exit_bound: assert property ($fell(cke) |-> ##[1:60] cke)
    else $error("self refresh never left");
  a_cke_after_exit: assert property ($rose(cke) |-> cke [*8])
    else $error("clock enable dropped after exit");
  a_odt_low_sr: assert property (!cke |-> !odt)
    else $error("termination high in self refresh");
  a_col_low_bits: assert property (rd |-> addr[1:0] == 2'h0)
    else $error("read column bits not zero");
  a_lat_loop_on: assert property (rd && !lo |-> !dq_oe [*8] ##1 dq_oe)
    else $error("read latency wrong with loop on");
  a_lat_loop_off: assert property (rd && lo |-> !dq_oe [*7] ##1 dq_oe)
    else $error("read latency wrong with loop off");
  a_no_spurious: assert property ($rose(dq_oe) |-> $past(rd, 8) || $past(rd, 7))
    else $error("data driven without a read");
  a_beat_count: assert property ($rose(dq_oe) |-> dq_oe [*4] ##1 (!dq_oe or dq_oe [*4] ##1 !dq_oe))
    else $error("burst length wrong");
  a_alt_pattern: assert property ($rose(dq_oe) |-> !dq_out[0] ##1 dq_out[0] ##1 !dq_out[0] ##1 dq_out[0])
    else $error("pattern wrong");
  a_lane_copy: assert property (dq_oe |-> dq_upper_out == dq_out[0] &&
    (dq_out[7:1] == {7{dq_out[0]}} || dq_out[7:1] == 7'h00)) else $error("lane mapping wrong");
  a_calib_reads_only: assert property (cal && cmd |-> rd || (mrs && ba == calib_pkg::MR_THREE))
    else $error("non-read command while readout enabled");
  a_strobe_data: assert property (strobe == dq_oe)
    else $error("strobe not aligned with data");
endmodule

// ### tb/dram_calib_readout_dll_off_control_tb.sv
// bench: controller end and memory end joined by the link interface
// assumes the controller divides the link clock from clk
`timescale 1ns/100ps
module dram_calib_readout_dll_off_control_tb;
  logic clk, rst_n, go_loop_off, calib_read, calib_chop, calib_upper, loop_locked;
  logic busy, rd_valid, loop_off, calib_mode;
  logic [7:0] rd_byte;
  int err_total, compares, beats;
  dram_link_if lk ();
  calib_host calib_host_i (.clk(clk), .rst_n(rst_n), .go_loop_off(go_loop_off), .calib_read(calib_read),
    .calib_chop(calib_chop), .calib_upper(calib_upper), .loop_locked(loop_locked), .busy(busy),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .link(lk.host));
  calib_device calib_device_i (.rst_n(rst_n), .link(lk.device), .loop_off(loop_off), .calib_mode(calib_mode));
  dram_link_assertions dram_link_assertions_i (.link_clk(lk.link_clk), .rst_n(rst_n), .cke(lk.cke),
    .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .odt(lk.odt), .ba(lk.ba),
    .addr(lk.addr), .dq_out(lk.dq_out), .dq_upper_out(lk.dq_upper_out), .dq_oe(lk.dq_oe),
    .strobe(lk.strobe));
  // =========================================
  // shared tasks
  // counted on the falling link edge, where the data lanes are settled
  always @(negedge lk.link_clk) begin
    if (lk.dq_oe === 1'b1) beats++;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic idle_wait();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) begin
      chk("busy timeout", 8'h01, 8'h00);
      tally_and_finish();
    end
  endtask
  // a chopped burst lands in the low nibble of the byte handed over
  task automatic do_read(input logic ch, input logic up, input string what);
    logic [7:0] b;
    logic ok;
    logic cm;
    ok = 1'b0;
    b = 8'h00;
    cm = 1'b0;
    @(negedge clk);
    beats = 0;
    calib_chop = ch;
    calib_upper = up;
    calib_read = 1'b1;
    for (int i = 0; i < 4000 && !ok; i++) begin
      @(negedge clk);
      if (busy === 1'b1) calib_read = 1'b0;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        b = rd_byte;
        cm = calib_mode;
      end
    end
    calib_read = 1'b0;
    if (!ok) begin
      chk({what, " timeout"}, 8'h00, 8'h01);
      tally_and_finish();
    end
    chk({what, " data"}, b, ch ? 8'h0A : 8'hAA);
    chk({what, " readout on"}, {7'h00, cm}, 8'h01);
    chk({what, " beats"}, 8'(beats), ch ? 8'h04 : 8'h08);
    idle_wait();
    $display("test %s done", what);
  endtask
  // =========================================
  // scenarios
  task automatic t_reset();
    chk("cke", {7'h00, lk.cke}, 8'h01);
    chk("command", {4'h0, lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n}, {4'h0, calib_pkg::CMD_NOP});
    chk("loop_off", {7'h00, loop_off}, 8'h00);
    chk("calib_mode", {7'h00, calib_mode}, 8'h00);
    $display("test reset done");
  endtask
  // a read while the loop is unlocked must not reach the link
  task automatic t_refused();
    logic seen;
    seen = 1'b0;
    loop_locked = 1'b0;
    calib_read = 1'b1;
    repeat (200) begin
      @(negedge clk);
      if (rd_valid !== 1'b0 || lk.dq_oe !== 1'b0) seen = 1'b1;
    end
    calib_read = 1'b0;
    chk("unlocked read", {7'h00, seen}, 8'h00);
    chk("unlocked busy", {7'h00, busy}, 8'h00);
    loop_locked = 1'b1;
    $display("test refused done");
  endtask
  task automatic t_loop_off();
    go_loop_off = 1'b1;
    for (int i = 0; i < 100 && busy !== 1'b1; i++) @(negedge clk);
    go_loop_off = 1'b0;
    idle_wait();
    chk("loop_off set", {7'h00, loop_off}, 8'h01);
    do_read(1'b0, 1'b0, "loop off burst8");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    go_loop_off = 1'b0;
    calib_read = 1'b0;
    calib_chop = 1'b0;
    calib_upper = 1'b0;
    loop_locked = 1'b1;
    err_total = 0;
    compares = 0;
    beats = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_refused();
    do_read(1'b0, 1'b0, "burst8");
    chk("calib_mode cleared", {7'h00, calib_mode}, 8'h00);
    do_read(1'b1, 1'b0, "chop lower");
    do_read(1'b1, 1'b1, "chop upper");
    t_loop_off();
    tally_and_finish();
  end
endmodule
